// [rtl/isr_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef ISR_MAP_SVH
`define ISR_MAP_SVH

`define CONFIG_OFS       12'h054
`define STATUS_OFS       12'h058
`define ENABLE_OFS       12'h05c

`define SW_BIT           31
`define READY_BIT        30
`define TS_BIT           29
`define FABRIC_BIT       28
`define PHY2_BIT         27
`define PHY1_BIT         26
`define TXSTOP_BIT       25
`define RXSTOP_BIT       24
`define DROP_BIT         23
`define RSVD_HI_BIT      22
`define LOADED_BIT       21
`define RXDMA_BIT        20
`define WRAP_BIT         19
`define RSVD_LO_BIT      18
`define PWR_BIT          17
`define TX_STATUS_OVERFLOW_FLAG_BIT         16
`define OVERSIZE_BIT     15

`define W1C_MASK         32'hc3bb8000
`define RO_MASK          32'h3c000000
`define ENABLE_WR_MASK   32'hffbb8000
`define CONFIG_WR_MASK   32'hff000100
`define STATUS_RESET     32'h00000000
`define ENABLE_RESET     32'h00000000
`define CONFIG_RESET     32'h00000000
`define DATA_ZERO        32'h00000000

`define INTERVAL_HI      31
`define INTERVAL_LO      24
`define INTERVAL_CLR_BIT 14
`define HOLD_STS_BIT     13
`define MASTER_BIT       12
`define OUT_EN_BIT       8

`define UNIT_NS          10000
`define CLK_NS           4
`define UNIT_CYCLES      (`UNIT_NS / `CLK_NS)
`define TIMER_WRAP_VAL   16'hffff
`define TIMER_ZERO_VAL   16'h0000

`endif

// [rtl/isr_pkg.sv]
// Types shared by the interrupt status block
package isr_pkg;

    typedef enum logic [1:0] {
        HOLD_IDLE = 2'b01,
        HOLD_RUN  = 2'b10
    } hold_state_type;

    typedef logic [31:0] word_type;

endpackage

// [rtl/flag_if.sv]
// Set, clear and stored value of the sticky status flags
`timescale 1ns/1ps
interface flag_if;
    logic [31:0] set;
    logic [31:0] clr;
    logic [31:0] flag;
    modport owner (input set, input clr, output flag);
    modport user  (output set, output clr, input flag);
endinterface

// [rtl/flag_bank.sv]
// Bank of sticky write-one-to-clear flags
`timescale 1ns/1ps
`include "isr_map.svh"
module flag_bank
    import isr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    flag_if.owner    fl
);
    word_type flag_ff;
    word_type nxt_flag;

    // A set in the same cycle as its clear wins, so no event is lost
    assign nxt_flag = (flag_ff & ~fl.clr) | fl.set;
    assign fl.flag  = flag_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_ff <= `STATUS_RESET;
        end else begin
            flag_ff <= nxt_flag;
        end
    end
endmodule

// [rtl/isr_upper.sv]
// Upper interrupt status flags with enable, gating and hold-off interval
//
// Contract
// - Flags show source status regardless of enable
// - Writing one clears flag; zero leaves it
// - Bit 31 raised while software enable set
// - Bit 30 raised when device becomes accessible
// - Bits 29, 28 mirror timestamp, fabric pending
// - Bits 27, 26 mirror second, first PHY
// - Bit 25 set on requested transmitter halt
// - Bit 24 set when receiver halts
// - Bit 23 set when drop count MSB rises
// - Bit 21 set when marked buffer loaded
// - Bit 20 set when receive transfer done
// - Bit 19 set on timer wrap to maximum
// - Bit 17 set on configured power event
// - Bit 17 clears only after power bits cleared
// - Power interrupt bypasses the hold-off interval
// - Bit 16 set on status FIFO overflow
// - Bit 15 set on oversize receive packet
// - Enable bit selects flag for interrupt output
// - Global enable clear forces output inactive
// - Hold-off interval counted in 10 us units
`timescale 1ns/1ps
`include "isr_map.svh"
module isr_upper
    import isr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timestamp_unit_event,
    input  wire logic        fabric_pending,
    input  wire logic        second_phy_event,
    input  wire logic        first_phy_event,
    input  wire logic        tx_stop_request,
    input  wire logic        tx_halted,
    input  wire logic        rx_halted,
    input  wire logic        drop_count_msb,
    input  wire logic        buffer_loaded,
    input  wire logic        completion_notify_mark,
    input  wire logic        receive_transfer_done,
    input  wire logic [15:0] general_timer_count,
    input  wire logic        power_event,
    input  wire logic        power_control_pending,
    input  wire logic        tx_status_overflow,
    input  wire logic        oversize_receive,
    output logic             irq
);
    localparam logic [11:0] UNIT_LAST = 12'(`UNIT_CYCLES - 1);

    flag_if fl ();

    word_type       enable_ff;
    word_type       config_ff;
    word_type       prdata_ff;
    logic           pready_ff;
    logic           pslverr_ff;
    logic           irq_ff;
    logic           ready_done_ff;
    logic           drop_msb_ff;
    logic [15:0]    timer_prev_ff;
    logic           line_ff;
    logic [11:0]    unit_cnt_ff;
    logic [7:0]     units_ff;
    hold_state_type hold_ff;

    word_type       nxt_prdata;
    logic           nxt_irq;
    hold_state_type nxt_hold;
    logic [11:0]    nxt_unit_cnt;
    logic [7:0]     nxt_units;

    // Bus decode
    wire logic      acc       = psel & penable;
    wire logic      done      = acc & pready_ff;
    wire logic      hit_stat  = paddr == `STATUS_OFS;
    wire logic      hit_en    = paddr == `ENABLE_OFS;
    wire logic      hit_cfg   = paddr == `CONFIG_OFS;
    wire logic      mapped    = hit_stat | hit_en | hit_cfg;
    wire logic      wr_stat   = done & pwrite & hit_stat;
    wire logic      wr_en     = done & pwrite & hit_en;
    wire logic      wr_cfg    = done & pwrite & hit_cfg;

    // Source conditions, each a one-cycle or level set into the bank
    wire logic      ready_set = ~ready_done_ff;
    wire logic      drop_set  = drop_count_msb & ~drop_msb_ff;
    wire logic      wrap_set  = (timer_prev_ff == `TIMER_ZERO_VAL)
                              & (general_timer_count == `TIMER_WRAP_VAL);
    wire logic      stop_set  = tx_stop_request & tx_halted;
    wire logic      load_set  = buffer_loaded & completion_notify_mark;

    word_type       set_vec;
    word_type       clr_vec;
    word_type       summary;
    word_type       status_rd;
    word_type       config_rd;

    always_comb begin
        set_vec                = `DATA_ZERO;
        set_vec[`SW_BIT]       = enable_ff[`SW_BIT];
        set_vec[`READY_BIT]    = ready_set;
        set_vec[`TXSTOP_BIT]   = stop_set;
        set_vec[`RXSTOP_BIT]   = rx_halted;
        set_vec[`DROP_BIT]     = drop_set;
        set_vec[`LOADED_BIT]   = load_set;
        set_vec[`RXDMA_BIT]    = receive_transfer_done;
        set_vec[`WRAP_BIT]     = wrap_set;
        set_vec[`PWR_BIT]      = power_event;
        set_vec[`TX_STATUS_OVERFLOW_FLAG_BIT]     = tx_status_overflow;
        set_vec[`OVERSIZE_BIT] = oversize_receive;
    end

    always_comb begin
        clr_vec = wr_stat ? (pwdata & `W1C_MASK) : `DATA_ZERO;
        // Power flag cannot be acknowledged while its cause is still armed
        if (power_control_pending) begin
            clr_vec[`PWR_BIT] = 1'b0;
        end
    end

    always_comb begin
        summary              = `DATA_ZERO;
        summary[`TS_BIT]     = timestamp_unit_event;
        summary[`FABRIC_BIT] = fabric_pending;
        summary[`PHY2_BIT]   = second_phy_event;
        summary[`PHY1_BIT]   = first_phy_event;
    end

    assign fl.set = set_vec;
    assign fl.clr = clr_vec;

    flag_bank flags (
        .clk   (clk),
        .rst_b (rst_b),
        .fl    (fl)
    );

    // Status shows every source whatever the enables say
    assign status_rd = (fl.flag & `W1C_MASK) | summary;

    // Interrupt combination
    word_type       active;
    assign active = status_rd & enable_ff;
    wire logic      pwr_term   = active[`PWR_BIT];
    wire logic      other_line = |(active & ~(32'h1 << `PWR_BIT));
    wire logic      master     = pwr_term | other_line;
    wire logic      out_en     = config_ff[`OUT_EN_BIT];
    wire logic      in_hold    = hold_ff == HOLD_RUN;
    wire logic [7:0] interval  = config_ff[`INTERVAL_HI:`INTERVAL_LO];
    wire logic      restart    = wr_cfg & pwdata[`INTERVAL_CLR_BIT];
    wire logic      line_fell  = line_ff & ~other_line;
    wire logic      unit_end   = unit_cnt_ff == UNIT_LAST;
    wire logic      last_unit  = units_ff == interval - 8'h01;

    // Power source ignores the hold-off; global enable gates both
    assign nxt_irq = out_en & (pwr_term | (other_line & ~in_hold));

    always_comb begin
        config_rd                    = config_ff & `CONFIG_WR_MASK;
        config_rd[`HOLD_STS_BIT]     = in_hold;
        config_rd[`MASTER_BIT]       = master;
    end

    assign nxt_prdata = !mapped ? `DATA_ZERO
                      : hit_stat ? status_rd
                      : hit_en   ? enable_ff & `ENABLE_WR_MASK
                      : config_rd;

    // Hold-off: starts when the line drops, runs interval * 10 us
    always_comb begin
        nxt_hold     = hold_ff;
        nxt_unit_cnt = unit_cnt_ff;
        nxt_units    = units_ff;
        case (hold_ff)
            HOLD_IDLE: begin
                nxt_unit_cnt = 12'h000;
                nxt_units    = 8'h00;
                if ((line_fell | restart) && interval != 8'h00) begin
                    nxt_hold = HOLD_RUN;
                end
            end
            HOLD_RUN: begin
                nxt_unit_cnt = unit_end ? 12'h000 : unit_cnt_ff + 12'h001;
                if (unit_end) begin
                    nxt_units = units_ff + 8'h01;
                end
                // A zero interval drops the hold and lets pending work out
                if (interval == 8'h00 || (unit_end && last_unit)) begin
                    nxt_hold = HOLD_IDLE;
                end
                // Restart opens a fresh interval even on the final unit
                if (restart && interval != 8'h00) begin
                    nxt_hold     = HOLD_RUN;
                    nxt_unit_cnt = 12'h000;
                    nxt_units    = 8'h00;
                end
            end
            default: begin
                nxt_hold     = HOLD_IDLE;
                nxt_unit_cnt = 12'h000;
                nxt_units    = 8'h00;
            end
        endcase
    end

    // One wait state keeps every bus output a flip-flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= `DATA_ZERO;
        end else begin
            pready_ff  <= acc & ~pready_ff;
            pslverr_ff <= acc & ~pready_ff & ~mapped;
            prdata_ff  <= (acc & ~pready_ff & ~pwrite) ? nxt_prdata
                                                       : `DATA_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_ff <= `ENABLE_RESET;
            config_ff <= `CONFIG_RESET;
        end else begin
            if (wr_en) begin
                enable_ff <= pwdata & `ENABLE_WR_MASK;
            end
            if (wr_cfg) begin
                config_ff <= pwdata & `CONFIG_WR_MASK;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_done_ff <= 1'b0;
            drop_msb_ff   <= 1'b0;
            timer_prev_ff <= `TIMER_WRAP_VAL;
        end else begin
            ready_done_ff <= 1'b1;
            drop_msb_ff   <= drop_count_msb;
            timer_prev_ff <= general_timer_count;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_ff     <= HOLD_IDLE;
            unit_cnt_ff <= 12'h000;
            units_ff    <= 8'h00;
            line_ff     <= 1'b0;
            irq_ff      <= 1'b0;
        end else begin
            hold_ff     <= nxt_hold;
            unit_cnt_ff <= nxt_unit_cnt;
            units_ff    <= nxt_units;
            line_ff     <= other_line;
            irq_ff      <= nxt_irq;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq     = irq_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence status_read_s;
        acc & ~pready_ff & ~pwrite & hit_stat;
    endsequence

    sequence clear_write_s(int b);
        wr_stat && pwdata[b] && !set_vec[b];
    endsequence

    ro_summary_a: assert property (status_read_s |=>
        prdata_ff[29:26] == $past(summary[29:26]))
        else $error("summary bits differ from sources");
    reserved_zero_a: assert property (status_read_s |=>
        !prdata_ff[22] && !prdata_ff[18])
        else $error("reserved status bit read as one");
    w1c_clear_a: assert property (clear_write_s(25) |=>
        !fl.flag[25])
        else $error("write one did not clear flag");
    set_wins_a: assert property (set_vec[15] |=> fl.flag[15])
        else $error("oversize event lost");
    sw_flag_a: assert property (enable_ff[31] |=> fl.flag[31])
        else $error("software flag not raised");
    pwr_keep_a: assert property (power_control_pending &&
        fl.flag[17] && wr_stat |=> fl.flag[17])
        else $error("power flag cleared while armed");
    flag_hold_a: assert property (fl.flag[24] && !clr_vec[24]
        |=> fl.flag[24])
        else $error("sticky flag dropped by itself");
    out_gate_a: assert property (!out_en |=> !irq_ff)
        else $error("output active while disabled");
    pwr_bypass_a: assert property (pwr_term && out_en && in_hold
        |=> irq_ff)
        else $error("power interrupt held off");
    hold_off_a: assert property (in_hold && !pwr_term |=> !irq_ff)
        else $error("interrupt during hold-off");
    ready_once_a: assert property (!ready_done_ff |=> fl.flag[30])
        else $error("ready flag not raised");

    // Config read returns the live master line, not a stored copy
    sequence config_read_s;
        acc & ~pready_ff & ~pwrite & hit_cfg;
    endsequence

    master_read_a: assert property (config_read_s |=>
        prdata_ff[`MASTER_BIT] == $past(master))
        else $error("master bit differs from enabled flags");
    stop_set_a: assert property (stop_set |=> fl.flag[25])
        else $error("transmitter halt event lost");
    drop_edge_a: assert property (drop_set |=> fl.flag[23])
        else $error("drop midpoint event lost");
    wrap_set_a: assert property (wrap_set |=> fl.flag[19])
        else $error("timer wrap event lost");
    pwr_clear_a: assert property (wr_stat && pwdata[17] &&
        !set_vec[17] && !power_control_pending |=> !fl.flag[17])
        else $error("power flag not cleared");
    hold_start_a: assert property (line_fell && !in_hold
        && interval != 8'h00 |=> in_hold)
        else $error("hold-off did not start");
    hold_zero_a: assert property (in_hold && interval == 8'h00
        |=> !in_hold)
        else $error("zero interval kept hold-off");
    unit_step_a: assert property (in_hold && !unit_end && !restart
        |=> unit_cnt_ff == $past(unit_cnt_ff) + 12'h001)
        else $error("hold-off counter skipped");
    out_path_a: assert property (other_line && out_en && !in_hold
        |=> irq_ff)
        else $error("enabled interrupt not driven");
endmodule

// [tb/isr_upper_bench.sv]
// Self-checking bench for the upper interrupt status block
`timescale 1ns/1ps
`include "isr_map.svh"
module isr_upper_bench
    import isr_pkg::*;
;
    typedef struct packed {
        logic [13:0] drv;
        logic        live;
        word_type    exp;
    } row_type;

    // Source bits: 0 ts, 1 fabric, 2 phy2, 3 phy1, 4 stop req, 5 tx halt,
    // 6 rx halt, 7 drop msb, 8 loaded, 9 notify, 10 rx done, 11 power,
    // 12 status overflow, 13 oversize
    row_type rows [15] = '{
        '{14'h0001, 1'b1, 32'h20000000}, '{14'h0002, 1'b1, 32'h10000000},
        '{14'h0004, 1'b1, 32'h08000000}, '{14'h0008, 1'b1, 32'h04000000},
        '{14'h0030, 1'b0, 32'h02000000}, '{14'h0010, 1'b0, 32'h00000000},
        '{14'h0020, 1'b0, 32'h00000000}, '{14'h0040, 1'b0, 32'h01000000},
        '{14'h0080, 1'b0, 32'h00800000}, '{14'h0300, 1'b0, 32'h00200000},
        '{14'h0100, 1'b0, 32'h00000000}, '{14'h0400, 1'b0, 32'h00100000},
        '{14'h0800, 1'b0, 32'h00020000}, '{14'h1000, 1'b0, 32'h00010000},
        '{14'h2000, 1'b0, 32'h00008000}
    };

    logic        clk;
    logic        rst_b;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    word_type    pwdata;
    word_type    prdata;
    logic        pready;
    logic        pslverr;
    logic [13:0] src;
    logic [15:0] gcnt;
    logic        pcp;
    logic        irq;
    logic        err;
    word_type    q;
    int          miscompares;
    int          tests_run;

    isr_upper DUT (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .timestamp_unit_event(src[0]), .fabric_pending(src[1]),
        .second_phy_event(src[2]), .first_phy_event(src[3]),
        .tx_stop_request(src[4]), .tx_halted(src[5]), .rx_halted(src[6]),
        .drop_count_msb(src[7]), .buffer_loaded(src[8]),
        .completion_notify_mark(src[9]), .receive_transfer_done(src[10]),
        .general_timer_count(gcnt), .power_event(src[11]),
        .power_control_pending(pcp), .tx_status_overflow(src[12]),
        .oversize_receive(src[13]), .irq(irq)
    );

    always #2 clk = ~clk;

    task automatic test_done();
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input word_type seen, input word_type exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request is held until pready is sampled high; wait is bounded
    task automatic apb(input logic wr, input logic [11:0] a, input word_type d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(word_type'(pready), 32'h1);
    endtask

    task automatic wr(input logic [11:0] a, input word_type d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input word_type exp);
        apb(1'b0, a, `DATA_ZERO);
        chk(q, exp);
        chk(word_type'(err), 32'h0);
    endtask

    task automatic pulse(input logic [13:0] d);
        @(posedge clk);
        src <= d;
        @(posedge clk);
        src <= '0;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end

    initial begin
        clk = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
        pwdata = '0; src = '0; gcnt = 16'h1234; pcp = 0;
        miscompares = 0; tests_run = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(`STATUS_OFS, 32'h40000000);
        rd(`ENABLE_OFS, `ENABLE_RESET);
        rd(`CONFIG_OFS, `CONFIG_RESET);
        wr(`STATUS_OFS, 32'h40000000);
        rd(`STATUS_OFS, 32'h0);
        wr(`ENABLE_OFS, 32'hffffffff);
        rd(`ENABLE_OFS, `ENABLE_WR_MASK);
        rd(`STATUS_OFS, 32'h80000000);
        // Clearing while still enabled must not stick
        wr(`STATUS_OFS, 32'h80000000);
        rd(`STATUS_OFS, 32'h80000000);
        wr(`ENABLE_OFS, 32'h0);
        wr(`STATUS_OFS, 32'h80000000);
        rd(`STATUS_OFS, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk(q, 32'h0);
        chk(word_type'(err), 32'h1);
        foreach (rows[i]) begin
            if (rows[i].live) begin
                @(posedge clk);
                src <= rows[i].drv;
            end else begin
                pulse(rows[i].drv);
            end
            rd(`STATUS_OFS, rows[i].exp);
            wr(`STATUS_OFS, ~rows[i].exp);
            rd(`STATUS_OFS, rows[i].exp);
            wr(`STATUS_OFS, rows[i].exp);
            rd(`STATUS_OFS, rows[i].live ? rows[i].exp : 32'h0);
            src <= '0;
            rd(`STATUS_OFS, 32'h0);
        end
        @(posedge clk) gcnt <= 16'h0000;
        @(posedge clk) gcnt <= 16'hffff;
        rd(`STATUS_OFS, 32'h00080000);
        wr(`STATUS_OFS, 32'h00080000);
        @(posedge clk) gcnt <= 16'hfffe;
        rd(`STATUS_OFS, 32'h0);
        // A counter sitting above midpoint must not re-raise the flag
        @(posedge clk) src <= 14'h0080;
        rd(`STATUS_OFS, 32'h00800000);
        wr(`STATUS_OFS, 32'h00800000);
        rd(`STATUS_OFS, 32'h0);
        src <= '0;
        pcp <= 1'b1;
        pulse(14'h0800);
        wr(`STATUS_OFS, 32'h00020000);
        rd(`STATUS_OFS, 32'h00020000);
        pcp <= 1'b0;
        wr(`STATUS_OFS, 32'h00020000);
        rd(`STATUS_OFS, 32'h0);
        wr(`ENABLE_OFS, 32'h00028000);
        wr(`CONFIG_OFS, 32'h01000100);
        pulse(14'h2000);
        repeat (4) @(posedge clk);
        chk(word_type'(irq), 32'h1);
        wr(`CONFIG_OFS, 32'h01000000);
        repeat (4) @(posedge clk);
        chk(word_type'(irq), 32'h0);
        rd(`STATUS_OFS, 32'h00008000);
        wr(`CONFIG_OFS, 32'h01000100);
        wr(`STATUS_OFS, 32'h00008000);
        pulse(14'h2000);
        repeat (4) @(posedge clk);
        chk(word_type'(irq), 32'h0);
        apb(1'b0, `CONFIG_OFS, 32'h0);
        chk(q & 32'h00002000, 32'h00002000);
        pulse(14'h0800);
        repeat (4) @(posedge clk);
        chk(word_type'(irq), 32'h1);
        wr(`STATUS_OFS, 32'h00020000);
        repeat (4) @(posedge clk);
        chk(word_type'(irq), 32'h0);
        // Interval is one unit; stay clear of both ends by a margin
        repeat (`UNIT_CYCLES - 150) @(posedge clk);
        chk(word_type'(irq), 32'h0);
        repeat (200) @(posedge clk);
        chk(word_type'(irq), 32'h1);
        // Restart write opens a new interval; a zero interval ends it
        wr(`CONFIG_OFS, 32'h01004100);
        repeat (4) @(posedge clk);
        chk(word_type'(irq), 32'h0);
        apb(1'b0, `CONFIG_OFS, 32'h0);
        chk(q, 32'h01003100);
        wr(`CONFIG_OFS, 32'h00000100);
        repeat (4) @(posedge clk);
        chk(word_type'(irq), 32'h1);
        wr(`CONFIG_OFS, 32'h0);
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk(word_type'(irq), 32'h0);
        rst_b <= 1'b1;
        rd(`STATUS_OFS, 32'h40000000);
        rd(`ENABLE_OFS, 32'h0);
        test_done();
    end
endmodule
